// ==== logic/dlp_regs.vh ====
// Constants for the latch, power-down and serial control of the volatile DAC.
`ifndef DLP_REGS_VH
`define DLP_REGS_VH

// Resolution and channel count of this variant.
`define DLP_RES             12
`define DLP_CHANNELS        2

// Serial frame layout.
`define DLP_FRAME_BITS      24
`define DLP_LAST_BIT        5'h17
`define DLP_ADDR_DONE       5'h04
`define DLP_CMD_DONE        5'h06
`define DLP_ERR_BIT         5'h07
`define DLP_DATA_START      5'h08

// Command field encodings.
`define DLP_CMD_WRITE       2'h0
`define DLP_CMD_READ        2'h3

// Memory addresses.
`define DLP_ADDR_CHANNEL_ZERO_VALUE       5'h00
`define DLP_ADDR_CHANNEL_ONE_VALUE       5'h01
`define DLP_ADDR_VREF       5'h08
`define DLP_ADDR_PD         5'h09
`define DLP_ADDR_GAIN_STAT  5'h0A
`define DLP_ADDR_RESET      5'h00

// Field positions in the gain and status word.
`define DLP_GAIN_LSB        8
`define DLP_POR_BIT         7

// Power-down select encodings.
`define DLP_PD_NORMAL       2'h0
`define DLP_PD_1K           2'h1
`define DLP_PD_100K         2'h2
`define DLP_PD_OPEN         2'h3

// Reference source encodings used by the enables.
`define DLP_REF_VDD         2'h0
`define DLP_REF_BANDGAP     2'h1
`define DLP_REF_PIN_UNBUF   2'h2
`define DLP_REF_PIN_BUF     2'h3

// Power-on defaults.
`define DLP_DAC_DEFAULT     12'h7FF
`define DLP_VREF_DEFAULT    4'h0
`define DLP_PD_DEFAULT      4'h0
`define DLP_GAIN_DEFAULT    2'h0
`define DLP_POR_DEFAULT     1'h1

// Reset values of the pin synchronisers: {brown-out, latch, data, clock, select}.
`define DLP_SYNC_RESET      5'h09

`endif

// ==== logic/dlp_sync2.v ====
// Two-flop synchroniser for one asynchronous input.
`timescale 1ns/1ns
module dlp_sync2 #(
   parameter RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire clock_i,
   input  wire rst_b_i,
   // Data
   input  wire d_i,
   output wire q_o
);

   reg stage1;
   reg stage2;

   // The first stage feeds only the second stage.
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage1 <= RST_VAL;
         stage2 <= RST_VAL;
      end else begin
         stage1 <= d_i;
         stage2 <= stage1;
      end
   end

   assign q_o = stage2;

endmodule // dlp_sync2

// ==== logic/dlp_dac_ctrl.v ====
// Latch, power-down and SPI slave control of a two-channel volatile DAC.
//
// What this block does
// R1 - Latch pin high blocks register-to-wiper copies; register writes still land.
// R2 - Latch low is level sensitive: new register value reaches wiper on the next clock.
// R3 - Latch pin is asynchronous to serial activity and may move anytime.
// R4 - All channels on the latch pin update their wipers together.
// R5 - Power-down select: 00 normal, 01 1k pull-down, 10 100k, 11 open.
// R6 - Each channel has its own power-down select, applied only to itself.
// R7 - Any non-zero power-down disables output amplifier and disconnects the ladder.
// R8 - Power-down bits change only by serial write or power-on or brown-out reload.
// R9 - Serial interface stays fully working in every power-down setting.
// R10 - Writing 00 leaves power-down: amplifier, ladder, reference back, pull-down off.
// R11 - After power-down exit output follows current register and configuration.
// R12 - Ladder buffer on only normal with ref 01/11; bandgap on when ref 01.
// R13 - Volatile DAC registers are 12, 10 or 8 bits per variant.
// R14 - Power-up loads defaults into all volatile memory before host updates.
// R15 - Power-on status bit sets after power-on; read of status clears it.
// R16 - Device is only an SPI slave; master supplies clock and select.
// R17 - Modes 0,0 and 1,1 only, chosen by clock level at select fall.
// R18 - Master keeps clock at most 20 MHz writes and 10 MHz reads.
// R19 - Power-on or brown-out resets the serial machine and address pointer.
// R20 - Transfers are 24-bit units framed by select; device counts bits.
// R21 - Select inactive resets serial module and pointer and ignores clock and data.
// R22 - Serial input is sampled on rising serial clock edges.
// R23 - Serial output changes on falling serial clock edges.
// R24 - Latch input passes a two-stage synchroniser before gating transfers.
`timescale 1ns/1ns
`include "dlp_regs.vh"
module dlp_dac_ctrl (
   // Clock and power-on reset
   input  wire                          clock_i,
   input  wire                          rst_b_i,
   input  wire                          brown_out_event_i,
   // Serial pins from the master
   input  wire                          cs_n_i,
   input  wire                          sck_i,
   input  wire                          serial_in_i,
   output wire                          serial_out_o,
   output wire                          serial_out_oe_o,
   // Latch pin
   input  wire                          output_update_gate_n_i,
   // Wipers and volatile registers
   output wire [`DLP_RES-1:0]           wiper0_o,
   output wire [`DLP_RES-1:0]           wiper1_o,
   output wire [`DLP_RES-1:0]           channel_zero_value_o,
   output wire [`DLP_RES-1:0]           channel_one_value_o,
   // Configuration and status
   output wire [2*`DLP_CHANNELS-1:0]    power_down_select_o,
   output wire [2*`DLP_CHANNELS-1:0]    reference_source_select_o,
   output wire [`DLP_CHANNELS-1:0]      gain_o,
   output wire                          por_status_o,
   output wire                          spi_mode_high_o,
   // Analog enables per channel
   output reg  [`DLP_CHANNELS-1:0]      out_amp_en_o,
   output reg  [`DLP_CHANNELS-1:0]      ladder_en_o,
   output reg  [`DLP_CHANNELS-1:0]      ladder_ref_conn_o,
   output reg  [`DLP_CHANNELS-1:0]      ladder_buf_en_o,
   output reg  [`DLP_CHANNELS-1:0]      bandgap_en_o,
   output reg  [`DLP_CHANNELS-1:0]      pull_down_1k_o,
   output reg  [`DLP_CHANNELS-1:0]      pull_down_100k_o
);

   localparam RES = `DLP_RES;
   localparam NCH = `DLP_CHANNELS;
   localparam [4:0] SYNC_RST = `DLP_SYNC_RESET;

   // Synchronised pins.
   wire [4:0] pin_raw;
   wire [4:0] pin_sync;
   wire       cs_n_s;
   wire       sck_s;
   wire       sdi_s;
   wire       lat_n_s;
   wire       bor_s;

   assign pin_raw = {brown_out_event_i, output_update_gate_n_i, serial_in_i, sck_i, cs_n_i};

   // Every pin crosses into the clock domain through two flops. The price is
   // about three clocks of latency, so the serial clock may not run faster
   // than about one eighth of the system clock.
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
         dlp_sync2 #(
            .RST_VAL (SYNC_RST[gi])
         ) u_sync (
            .clock_i (clock_i),
            .rst_b_i (rst_b_i),
            .d_i     (pin_raw[gi]),
            .q_o     (pin_sync[gi])
         ); // R3 R24
      end
   endgenerate

   assign cs_n_s  = pin_sync[0];
   assign sck_s   = pin_sync[1];
   assign sdi_s   = pin_sync[2];
   assign lat_n_s = pin_sync[3];
   assign bor_s   = pin_sync[4];

   // Edge finding on the sampled serial clock and select. The history flops
   // reset to the idle levels of their pins, so no false edge follows reset.
   reg  sck_q;
   reg  cs_n_q;
   wire sck_rise;
   wire sck_fall;
   wire cs_fall;
   wire active;

   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sck_q  <= 1'b0;
         cs_n_q <= 1'b1;
      end else begin
         sck_q  <= sck_s;
         cs_n_q <= cs_n_s;
      end
   end

   assign active   = ~cs_n_s;
   assign sck_rise = sck_s & ~sck_q;
   assign sck_fall = ~sck_s & sck_q;
   assign cs_fall  = ~cs_n_s & cs_n_q;

   // Serial slave state.
   reg [4:0]  bit_cnt;
   // Only the last data bits are kept; address and command are caught on the
   // fly as their last bit arrives.
   reg [14:0] shift_in;
   reg [4:0]  addr_ptr;
   reg [1:0]  cmd;
   reg        cmd_err;
   reg        mode_high;
   reg        serial_out;
   reg [15:0] out_shift;

   // Volatile memory.
   reg [2*RES-1:0] dac_flat;
   reg [3:0]       vref_sel;
   reg [3:0]       pd_sel;
   reg [1:0]       gain;
   reg             por_flag;

   wire        addr_ok;
   wire        cmd_ok;
   wire        wr_fire;
   wire        rd_load;
   wire [15:0] wr_data;
   reg  [15:0] rd_word;

   assign addr_ok = (addr_ptr == `DLP_ADDR_CHANNEL_ZERO_VALUE) | (addr_ptr == `DLP_ADDR_CHANNEL_ONE_VALUE) |
                    (addr_ptr == `DLP_ADDR_VREF) | (addr_ptr == `DLP_ADDR_PD) |
                    (addr_ptr == `DLP_ADDR_GAIN_STAT);
   assign cmd_ok  = (cmd == `DLP_CMD_WRITE) | (cmd == `DLP_CMD_READ);

   // A write takes effect on the rising edge that completes a 24-bit unit.
   // A frame cut short by the select never reaches memory.
   assign wr_data = {shift_in[14:0], sdi_s}; // R22
   assign wr_fire = active & ~bor_s & ~cs_fall & sck_rise & ~cmd_err &
                    (bit_cnt == `DLP_LAST_BIT) & (cmd == `DLP_CMD_WRITE); // R20

   // Read data is fetched on the falling edge that opens the data bytes.
   assign rd_load = active & ~bor_s & ~cs_fall & sck_fall & ~cmd_err &
                    (bit_cnt == `DLP_DATA_START) & (cmd == `DLP_CMD_READ);

   // Unused addresses read as zero; the command error bit already refuses them.
   always @* begin
      case (addr_ptr)
         `DLP_ADDR_CHANNEL_ZERO_VALUE:      rd_word = {{(16-RES){1'b0}}, dac_flat[RES-1:0]};
         `DLP_ADDR_CHANNEL_ONE_VALUE:      rd_word = {{(16-RES){1'b0}}, dac_flat[2*RES-1:RES]};
         `DLP_ADDR_VREF:      rd_word = {12'h000, vref_sel};
         `DLP_ADDR_PD:        rd_word = {12'h000, pd_sel};
         `DLP_ADDR_GAIN_STAT: rd_word = {6'h00, gain, por_flag, 7'h00};
         default:             rd_word = 16'h0000;
      endcase
   end

   // The slave runs the same in every power-down setting. R9
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bit_cnt   <= 5'h00;
         shift_in  <= 15'h0000;
         addr_ptr  <= `DLP_ADDR_RESET;
         cmd       <= 2'h0;
         cmd_err   <= 1'b0;
         mode_high <= 1'b0;
         serial_out       <= 1'b1;
         out_shift <= 16'hFFFF;
      end else if (bor_s || !active) begin
         // Brown-out or a released select puts the slave back to idle. R19 R21
         bit_cnt   <= 5'h00;
         addr_ptr  <= `DLP_ADDR_RESET;
         cmd       <= 2'h0;
         cmd_err   <= 1'b0;
         serial_out       <= 1'b1;
         out_shift <= 16'hFFFF;
      end else if (cs_fall) begin
         // Clock level at select fall picks the mode. R17
         mode_high <= sck_s;
         bit_cnt   <= 5'h00;
         serial_out       <= 1'b1;
      end else if (sck_rise) begin
         shift_in <= {shift_in[13:0], sdi_s}; // R22
         if (bit_cnt == `DLP_LAST_BIT) begin
            bit_cnt <= 5'h00; // R20
         end else begin
            bit_cnt <= bit_cnt + 5'h01;
         end
         if (bit_cnt == `DLP_ADDR_DONE) begin
            addr_ptr <= {shift_in[3:0], sdi_s};
         end
         if (bit_cnt == `DLP_CMD_DONE) begin
            cmd <= {shift_in[0], sdi_s};
         end
      end else if (sck_fall) begin
         // Output only moves on falling edges. R23
         // A refused command keeps the output low until the select is released.
         if (cmd_err) begin
            serial_out <= 1'b0;
         end else if (bit_cnt == `DLP_ERR_BIT) begin
            serial_out     <= addr_ok & cmd_ok;
            cmd_err <= ~(addr_ok & cmd_ok);
         end else if (rd_load) begin
            serial_out       <= rd_word[15];
            out_shift <= {rd_word[14:0], 1'b1};
         end else if ((bit_cnt > `DLP_DATA_START) && (cmd == `DLP_CMD_READ)) begin
            serial_out       <= out_shift[15];
            out_shift <= {out_shift[14:0], 1'b1};
         end else if (bit_cnt < `DLP_ERR_BIT) begin
            serial_out <= 1'b1;
         end
      end
   end

   // The pin is driven only while selected; the clock is never driven. R16
   assign serial_out_o    = serial_out;
   assign serial_out_oe_o = active;
   assign spi_mode_high_o = mode_high;

   // Volatile memory: defaults at power-on or brown-out, then host writes. R14
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dac_flat <= {NCH{`DLP_DAC_DEFAULT}};
         vref_sel <= `DLP_VREF_DEFAULT;
         pd_sel   <= `DLP_PD_DEFAULT;
         gain     <= `DLP_GAIN_DEFAULT;
         por_flag <= `DLP_POR_DEFAULT; // R15
      end else if (bor_s) begin
         dac_flat <= {NCH{`DLP_DAC_DEFAULT}}; // R14
         vref_sel <= `DLP_VREF_DEFAULT;
         pd_sel   <= `DLP_PD_DEFAULT; // R8
         gain     <= `DLP_GAIN_DEFAULT;
         por_flag <= `DLP_POR_DEFAULT; // R15
      end else begin
         if (wr_fire) begin
            case (addr_ptr)
               `DLP_ADDR_CHANNEL_ZERO_VALUE:      dac_flat[RES-1:0]     <= wr_data[RES-1:0]; // R1 R13
               `DLP_ADDR_CHANNEL_ONE_VALUE:      dac_flat[2*RES-1:RES] <= wr_data[RES-1:0]; // R1 R13
               `DLP_ADDR_VREF:      vref_sel <= wr_data[3:0];
               `DLP_ADDR_PD:        pd_sel   <= wr_data[3:0]; // R8 R10
               `DLP_ADDR_GAIN_STAT: gain     <= wr_data[`DLP_GAIN_LSB+1:`DLP_GAIN_LSB];
               default:             gain     <= gain;
            endcase
         end
         // Reading the status word clears the power-on flag. A brown-out in the
         // same cycle wins, since its branch above takes priority.
         if (rd_load && (addr_ptr == `DLP_ADDR_GAIN_STAT)) begin
            por_flag <= 1'b0; // R15
         end
      end
   end

   assign channel_zero_value_o     = dac_flat[RES-1:0];
   assign channel_one_value_o      = dac_flat[2*RES-1:RES];
   assign power_down_select_o      = pd_sel;
   assign reference_source_select_o = vref_sel;
   assign gain_o                   = gain;
   assign por_status_o             = por_flag;

   // Per-channel wipers and analog enables.
   reg  [2*RES-1:0] wiper_flat;
   wire [NCH-1:0]   next_normal;
   wire [NCH-1:0]   next_buf;
   wire [NCH-1:0]   next_bandgap;
   wire [NCH-1:0]   next_pd_1k;
   wire [NCH-1:0]   next_pd_100k;

   generate
      for (gi = 0; gi < NCH; gi = gi + 1) begin : g_chan
         wire [1:0] pd_ch;
         wire [1:0] ref_ch;

         assign pd_ch  = pd_sel[2*gi+1:2*gi]; // R6
         assign ref_ch = vref_sel[2*gi+1:2*gi];

         assign next_normal[gi]  = (pd_ch == `DLP_PD_NORMAL); // R5 R7 R10
         assign next_buf[gi]     = next_normal[gi] & ((ref_ch == `DLP_REF_BANDGAP) |
                                                      (ref_ch == `DLP_REF_PIN_BUF)); // R12
         assign next_bandgap[gi] = (ref_ch == `DLP_REF_BANDGAP); // R12
         assign next_pd_1k[gi]   = (pd_ch == `DLP_PD_1K); // R5
         assign next_pd_100k[gi] = (pd_ch == `DLP_PD_100K); // R5
      end
   endgenerate

   // Both wipers copy on the same synchronised latch level, so they move
   // together; while the latch is high they hold whatever the registers do.
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wiper_flat <= {NCH{`DLP_DAC_DEFAULT}};
      end else if (bor_s) begin
         wiper_flat <= {NCH{`DLP_DAC_DEFAULT}};
      end else if (!lat_n_s) begin
         wiper_flat <= dac_flat; // R1 R2 R4
      end
   end

   // Enables follow the current select one clock later, so leaving power-down
   // brings the output back at the current register value. The band-gap
   // follows the reference select alone, even in power-down.
   always @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         out_amp_en_o      <= {NCH{1'b0}};
         ladder_en_o       <= {NCH{1'b0}};
         ladder_ref_conn_o <= {NCH{1'b0}};
         ladder_buf_en_o   <= {NCH{1'b0}};
         bandgap_en_o      <= {NCH{1'b0}};
         pull_down_1k_o    <= {NCH{1'b0}};
         pull_down_100k_o  <= {NCH{1'b0}};
      end else begin
         out_amp_en_o      <= next_normal; // R7 R10 R11
         ladder_en_o       <= next_normal; // R7 R10
         ladder_ref_conn_o <= next_normal; // R7 R10
         ladder_buf_en_o   <= next_buf; // R12
         bandgap_en_o      <= next_bandgap; // R12
         pull_down_1k_o    <= next_pd_1k; // R5
         pull_down_100k_o  <= next_pd_100k; // R5
      end
   end

   assign wiper0_o = wiper_flat[RES-1:0];
   assign wiper1_o = wiper_flat[2*RES-1:RES];

endmodule // dlp_dac_ctrl

// ==== dv/dlp_dac_ctrl_asserts.sv ====
// Concurrent checks on the ports of the DAC control block.
`timescale 1ns/1ns
module dlp_dac_ctrl_asserts (
   // Clock, reset and pins
   input wire        clock_i,
   input wire        rst_b_i,
   input wire        brown_out_event_i,
   input wire        cs_n_i,
   input wire        output_update_gate_n_i,
   // Registers and status
   input wire [11:0] wiper0_o,
   input wire [11:0] wiper1_o,
   input wire [11:0] channel_zero_value_o,
   input wire [11:0] channel_one_value_o,
   input wire [3:0]  power_down_select_o,
   input wire [3:0]  reference_source_select_o,
   input wire        por_status_o,
   input wire        serial_out_oe_o,
   // Analog enables
   input wire [1:0]  out_amp_en_o,
   input wire [1:0]  pull_down_1k_o,
   input wire [1:0]  bandgap_en_o
);
   // Checks rest for five clocks after a reset or brown-out while the reload settles.
   logic [4:0] settle;
   always_ff @(posedge clock_i or negedge rst_b_i)
      if (!rst_b_i)
         settle <= 5'h1F;
      else
         settle <= {settle[3:0], brown_out_event_i};
   default clocking dc @(posedge clock_i); endclocking
   default disable iff (!rst_b_i || settle != 5'h00);
   sequence s_held; output_update_gate_n_i [*4]; endsequence
   sequence s_open; (!output_update_gate_n_i) [*4]; endsequence
   sequence s_idle; cs_n_i [*6]; endsequence
   chk_latch_hold: assert property (
      s_held |-> $stable(wiper0_o) && $stable(wiper1_o))
      else $error("wiper moved with latch high");
   chk_latch_copy: assert property (
      s_open ##0 $stable({channel_zero_value_o, channel_one_value_o})
      |-> {wiper0_o, wiper1_o} == {channel_zero_value_o, channel_one_value_o})
      else $error("wiper differs from register");
   chk_pd_load: assert property (
      pull_down_1k_o == {$past(power_down_select_o[3:2]) == 2'h1,
                         $past(power_down_select_o[1:0]) == 2'h1})
      else $error("pull-down differs from select");
   chk_amp_follow: assert property (
      out_amp_en_o == {$past(power_down_select_o[3:2]) == 2'h0,
                       $past(power_down_select_o[1:0]) == 2'h0})
      else $error("amplifier differs from select");
   chk_bandgap_ref: assert property (
      bandgap_en_o == {$past(reference_source_select_o[3:2]) == 2'h1,
                       $past(reference_source_select_o[1:0]) == 2'h1})
      else $error("band-gap differs from select");
   chk_oe_select: assert property (
      (!cs_n_i) [*3] |-> serial_out_oe_o)
      else $error("data out undriven while selected");
   chk_idle_stable: assert property (
      s_idle |-> $stable({power_down_select_o, channel_zero_value_o}))
      else $error("register moved while deselected");
   chk_por_sticky: assert property (
      !$rose(por_status_o) && (!$fell(por_status_o) || !cs_n_i))
      else $error("power-on flag moved");
endmodule // dlp_dac_ctrl_asserts

bind dlp_dac_ctrl dlp_dac_ctrl_asserts u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
   .brown_out_event_i(brown_out_event_i), .cs_n_i(cs_n_i),
   .output_update_gate_n_i(output_update_gate_n_i), .wiper0_o(wiper0_o),
   .wiper1_o(wiper1_o), .channel_zero_value_o(channel_zero_value_o),
   .channel_one_value_o(channel_one_value_o), .power_down_select_o(power_down_select_o),
   .reference_source_select_o(reference_source_select_o), .por_status_o(por_status_o),
   .serial_out_oe_o(serial_out_oe_o), .out_amp_en_o(out_amp_en_o),
   .pull_down_1k_o(pull_down_1k_o), .bandgap_en_o(bandgap_en_o));

// ==== dv/dlp_spi_host.sv ====
// Behavioural SPI master that drives the converter's serial pins.
`timescale 1ns/1ns
module dlp_spi_host (
   // Serial pins
   output logic cs_n_o,
   output logic sck_o,
   output logic sdo_o,
   input  wire  sdi_i
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      sdo_o = 1'b0;
   end
   // Sends nb bits of w, first bit first; the clock is set to its idle level m before the select falls.
   task automatic frame(input logic m, input int nb, input logic [47:0] w,
                        output logic [47:0] r);
      r = 48'h0;
      sck_o = m;
      #100 cs_n_o = 1'b0;
      #100;
      for (int i = nb - 1; i >= 0; i--) begin
         sck_o = 1'b0;
         sdo_o = w[i];
         #80 sck_o = 1'b1;
         #40 r = {r[46:0], sdi_i};
         #40;
      end
      sck_o = m;
      #80 cs_n_o = 1'b1;
      sdo_o = ~sdo_o;
      #100;
   endtask
endmodule // dlp_spi_host

// ==== dv/dlp_dac_ctrl_tb_top.sv ====
// Self-checking bench for the DAC latch, power-down and serial control.
`timescale 1ns/1ns
`include "dlp_regs.vh"
module dlp_dac_ctrl_tb_top;
   logic        clock_i, rst_b_i, bo, gate_n;
   wire         cs_n, sck, serial_in, serial_out, oe, por, mh;
   wire  [11:0] w0, w1, v0, v1;
   wire  [3:0]  pd, rs;
   wire  [1:0]  gn, amp, lad, rc, lb, bg, k1, k2;
   logic [11:0] m_dac [2], m_w [2];
   logic [3:0]  m_pd, m_rs;
   logic [1:0]  m_gn, g;
   logic        m_por;
   logic [47:0] r;
   int          err_total, checks_done;

   dlp_dac_ctrl dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .brown_out_event_i(bo),
      .cs_n_i(cs_n), .sck_i(sck), .serial_in_i(serial_in), .serial_out_o(serial_out),
      .serial_out_oe_o(oe), .output_update_gate_n_i(gate_n), .wiper0_o(w0),
      .wiper1_o(w1), .channel_zero_value_o(v0), .channel_one_value_o(v1),
      .power_down_select_o(pd), .reference_source_select_o(rs), .gain_o(gn),
      .por_status_o(por), .spi_mode_high_o(mh), .out_amp_en_o(amp),
      .ladder_en_o(lad), .ladder_ref_conn_o(rc), .ladder_buf_en_o(lb),
      .bandgap_en_o(bg), .pull_down_1k_o(k1), .pull_down_100k_o(k2));
   // The data-out line has a pull-up, seen whenever the converter leaves it.
   dlp_spi_host host (.cs_n_o(cs_n), .sck_o(sck), .sdo_o(serial_in), .sdi_i(oe ? serial_out : 1'b1));

   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   initial begin
      #2000000;
      err_total++;
      conclude;
   end
   task automatic check(input string nm, input logic [47:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #2;
   endtask
   function automatic logic [23:0] wr(input logic [4:0] a, input logic [15:0] d);
      return {a, `DLP_CMD_WRITE, 1'b0, d};
   endfunction
   task automatic mreset;
      m_dac = '{2{`DLP_DAC_DEFAULT}};
      m_w = m_dac;
      m_pd = `DLP_PD_DEFAULT;
      m_rs = `DLP_VREF_DEFAULT;
      m_gn = `DLP_GAIN_DEFAULT;
      m_por = `DLP_POR_DEFAULT;
   endtask
   // One frame; only whole 24-bit units reach the model.
   task automatic xf(input logic m, input int nb, input logic [47:0] x);
      logic [23:0] u;
      step(1);
      host.frame(m, nb, x, r);
      for (int i = 0; i < nb / 24 && nb % 24 == 0; i++) begin
         u = x[24 * (nb / 24 - 1 - i) +: 24];
         if (u[18:17] == `DLP_CMD_READ && u[23:19] == `DLP_ADDR_GAIN_STAT)
            m_por = 1'b0;
         else if (u[18:17] == `DLP_CMD_WRITE)
            case (u[23:19])
               `DLP_ADDR_CHANNEL_ZERO_VALUE: m_dac[0] = u[11:0];
               `DLP_ADDR_CHANNEL_ONE_VALUE: m_dac[1] = u[11:0];
               `DLP_ADDR_VREF: m_rs = u[3:0];
               `DLP_ADDR_PD: m_pd = u[3:0];
               `DLP_ADDR_GAIN_STAT: m_gn = u[9:8];
               default: ;
            endcase
      end
   endtask
   task automatic cmp;
      logic [1:0] a, p1, p2, gb, bf;
      for (int c = 0; c < 2; c++) begin
         a[c] = m_pd[2 * c +: 2] == `DLP_PD_NORMAL;
         p1[c] = m_pd[2 * c +: 2] == `DLP_PD_1K;
         p2[c] = m_pd[2 * c +: 2] == `DLP_PD_100K;
         gb[c] = m_rs[2 * c +: 2] == `DLP_REF_BANDGAP;
         bf[c] = a[c] && (gb[c] || m_rs[2 * c +: 2] == `DLP_REF_PIN_BUF);
      end
      if (!gate_n)
         m_w = m_dac;
      check("values", {v0, v1}, {m_dac[0], m_dac[1]});
      check("wipers", {w0, w1}, {m_w[0], m_w[1]});
      check("selects", {pd, rs, gn, por}, {m_pd, m_rs, m_gn, m_por});
      check("amp", {amp, rc}, {a, a});
      check("ladder", lad, a);
      check("pulldown", {k1, k2}, {p1, p2});
      check("refen", {bg, lb}, {gb, bf});
   endtask
   task automatic conclude;
      $display("mismatches %0d of %0d checks", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      rst_b_i = 1'b0;
      bo = 1'b0;
      gate_n = 1'b1;
      err_total = 0;
      checks_done = 0;
      void'($urandom(12));
      mreset;
      step(3);
      rst_b_i = 1'b1;
      step(4);
      cmp;
      xf(1'b0, 48, {wr(`DLP_ADDR_CHANNEL_ZERO_VALUE, 16'($urandom)), wr(`DLP_ADDR_CHANNEL_ONE_VALUE, 16'($urandom))});
      cmp;
      check("cmderr", {r[40], r[16], mh}, 3'h6);
      gate_n = 1'b0;
      step(4);
      cmp;
      xf(1'b1, 24, wr(`DLP_ADDR_CHANNEL_ZERO_VALUE, 16'($urandom)));
      cmp;
      check("mode", mh, 1'b1);
      for (int p = 0; p < 4; p++) begin
         xf(p[0], 24, wr(`DLP_ADDR_PD, {12'h000, 2'(3 - p), 2'(p)}));
         xf(1'b0, 24, {`DLP_ADDR_CHANNEL_ONE_VALUE, `DLP_CMD_READ, 17'h00000});
         check("readback", r[16:0], {5'h10, m_dac[1]});
         cmp;
      end
      for (int s = 0; s < 4; s++) begin
         xf(1'b1, 24, wr(`DLP_ADDR_VREF, {12'h000, 2'(s), 2'(3 - s)}));
         cmp;
      end
      xf(1'b0, 24, wr(`DLP_ADDR_VREF, 16'h0005));
      xf(1'b0, 24, wr(`DLP_ADDR_PD, 16'h000F));
      cmp;
      xf(1'b0, 24, wr(`DLP_ADDR_PD, 16'h0000));
      cmp;
      g = 2'($urandom);
      xf(1'b0, 24, wr(`DLP_ADDR_GAIN_STAT, {6'h00, g, 8'h00}));
      xf(1'b0, 24, {`DLP_ADDR_GAIN_STAT, `DLP_CMD_READ, 17'h00000});
      check("status", r[9:7], {g, 1'b1});
      xf(1'b1, 24, {`DLP_ADDR_GAIN_STAT, `DLP_CMD_READ, 17'h00000});
      check("status", r[9:7], {g, 1'b0});
      xf(1'b0, 24, {`DLP_ADDR_CHANNEL_ZERO_VALUE, 2'h1, 17'h0FFFF});
      check("error", r[16:0], 17'h00000);
      xf(1'b0, 12, wr(`DLP_ADDR_CHANNEL_ZERO_VALUE, 16'h0ABC) >> 12);
      cmp;
      xf(1'b0, 24, wr(`DLP_ADDR_CHANNEL_ONE_VALUE, 16'h0123));
      bo = 1'b1;
      step(4);
      bo = 1'b0;
      step(4);
      mreset;
      cmp;
      xf(1'b1, 24, {`DLP_ADDR_CHANNEL_ONE_VALUE, `DLP_CMD_READ, 17'h00000});
      check("readback", r[16:0], {5'h10, `DLP_DAC_DEFAULT});
      conclude;
   end
endmodule // dlp_dac_ctrl_tb_top
